/* File: inc/ues_pkg.sv */
package ues_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W     = 8;
    localparam int         DATA_W     = 32;
    localparam logic [7:0] ADDR_CSR   = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h04;
    localparam logic [7:0] ADDR_FIFO  = 8'h08;
    localparam logic [7:0] ADDR_MASK  = 8'h0C;

    // ----------------------------------------------------------------
    // endpoint_control_status field positions
    // ----------------------------------------------------------------
    localparam int CSR_TXC    = 0;   // tx_complete, write one to clear
    localparam int CSR_HSENT  = 1;   // halt_handshake_sent, write one to clear
    localparam int CSR_PKTR   = 2;   // tx_packet_ready, bank-confirmed readback
    localparam int CSR_FHALT  = 3;   // force_halt_handshake
    localparam int CSR_PSTALL = 4;   // protocol stall, control endpoints only
    localparam int CSR_SETUP  = 5;   // setup received, write one to clear
    localparam int CSR_W      = 6;
    localparam int RST_BIT    = 0;   // endpoint reset trigger bit

    localparam logic [5:0]  MASK_RST  = 6'h00;
    localparam logic [5:0]  IRQ_BITS  = 6'h23;   // sticky bits that may interrupt
    localparam logic [25:0] CSR_PAD   = 26'h0000000;

    // ----------------------------------------------------------------
    // bank sizing and link encodings
    // ----------------------------------------------------------------
    localparam int BANK_DEPTH = 64;

    typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_SETUP = 2'b10} ues_tok_t;
    typedef enum logic [1:0] {PID_ACK = 2'b00, PID_NAK = 2'b01, PID_STALL = 2'b10} ues_pid_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01, ST_WAIT = 2'b10} ues_state_t;

endpackage

/* File: inc/ues_bank_if.sv */
`timescale 1ns/1ns
interface ues_bank_if;
    // requests from the endpoint controller
    logic       wr_en;
    logic [7:0] wr_data;
    logic       commit;
    logic       uncommit;
    logic       flush;
    logic       start;
    logic       rd_en;
    logic       rel;
    logic       abort;
    // answers from the bank store
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_last;
    logic       rd_more;
    logic       empty;
    logic       pr_flag;
    logic       send_ready;

    modport ctl  (output wr_en, wr_data, commit, uncommit, flush, start, rd_en, rel, abort,
                  input  rd_data, rd_valid, rd_last, rd_more, empty, pr_flag, send_ready);
    modport bank (input  wr_en, wr_data, commit, uncommit, flush, start, rd_en, rel, abort,
                  output rd_data, rd_valid, rd_last, rd_more, empty, pr_flag, send_ready);
endinterface

/* File: core/ues_bank.sv */
`timescale 1ns/1ns
module ues_bank
    import ues_pkg::*;
#(
    parameter int DEPTH = BANK_DEPTH,
    parameter bit DUAL  = 1'b0
)(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // controller side
    ues_bank_if.bank bi
);

    localparam int AW = $clog2(DEPTH);

    logic [7:0]  mem [0:2*DEPTH-1];
    logic [AW:0] cnt [0:1];
    logic [1:0]  full;
    logic        fill_sel;
    logic        send_sel;
    logic        sending;
    logic [AW:0] rd_ptr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        rd_last;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire         last_sel  = DUAL ? ~fill_sel : 1'b0;
    wire         wr_ok     = bi.wr_en && !full[fill_sel] && (cnt[fill_sel] < (AW+1)'(DEPTH));
    wire [AW:0]  rd_next   = rd_ptr + (AW+1)'(1);
    wire         rd_is_end = rd_next == cnt[send_sel];
    // the bank being sent may not be withdrawn, else the link would emit freed bytes
    wire         unc_ok    = bi.uncommit && full[last_sel] && !(sending && last_sel == send_sel);

    assign bi.rd_data    = rd_data;
    assign bi.rd_valid   = rd_valid;
    assign bi.rd_last    = rd_last;
    assign bi.rd_more    = sending && (rd_ptr < cnt[send_sel]);
    assign bi.empty      = cnt[send_sel] == '0;
    assign bi.pr_flag    = full[last_sel];
    assign bi.send_ready = full[send_sel];

    // ----------------------------------------------------------------
    // byte store, read data registered
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr_ok)
            mem[{fill_sel, cnt[fill_sel][AW-1:0]}] <= bi.wr_data;
        if (bi.rd_en)
            rd_data <= mem[{send_sel, rd_ptr[AW-1:0]}];
    end

    // ----------------------------------------------------------------
    // bank bookkeeping; flush drops pointers and ready marks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt[0] <= '0; cnt[1] <= '0; full <= 2'h0; fill_sel <= 1'b0;
            send_sel <= 1'b0; sending <= 1'b0; rd_ptr <= '0; rd_valid <= 1'b0; rd_last <= 1'b0;
        end
        else if (bi.flush)
        begin
            cnt[0] <= '0; cnt[1] <= '0; full <= 2'h0; fill_sel <= 1'b0;
            send_sel <= 1'b0; sending <= 1'b0; rd_ptr <= '0; rd_valid <= 1'b0; rd_last <= 1'b0;
        end
        else
        begin
            rd_valid <= bi.rd_en;
            rd_last  <= bi.rd_en && rd_is_end;
            if (wr_ok)
                cnt[fill_sel] <= cnt[fill_sel] + (AW+1)'(1);
            // packet-ready writes reach the readback only here, once the bank has taken the change; release and flush also clear it
            if (bi.commit && !full[fill_sel])
            begin
                full[fill_sel] <= 1'b1;
                fill_sel       <= DUAL ? ~fill_sel : fill_sel;
            end
            else if (unc_ok)
            begin
                full[last_sel] <= 1'b0;
                fill_sel       <= last_sel;
            end
            if (bi.start)
            begin
                sending <= 1'b1;
                rd_ptr  <= '0;
            end
            else if (bi.rd_en)
                rd_ptr <= rd_next;
            if (bi.rel)
            begin
                full[send_sel] <= 1'b0;
                cnt[send_sel]  <= '0;
                send_sel       <= DUAL ? ~send_sel : send_sel;
                sending        <= 1'b0;
            end
            else if (bi.abort)
                sending <= 1'b0;
        end
    end

    a_flush_clears: assert property (@(posedge clk) disable iff (!arst_n)
        bi.flush |=> !bi.pr_flag && !bi.send_ready && bi.empty)
        else $error("flush left a bank ready");

endmodule

/* File: core/ues_endpoint.sv */
`timescale 1ns/1ns
module ues_endpoint
    import ues_pkg::*;
#(
    parameter int DEPTH      = BANK_DEPTH,
    parameter bit DUAL_BANK  = 1'b0,
    parameter bit IS_CONTROL = 1'b1
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // interrupt
    output logic                   irq,
    // token and handshake link
    input  wire logic              tok_valid,
    input  wire ues_tok_t          tok_kind,
    input  wire logic              host_ack,
    output logic                   hs_valid,
    output ues_pid_t               hs_pid,
    // IN data stream
    output logic                   tx_valid,
    output logic      [7:0]        tx_data,
    output logic                   tx_last,
    output logic                   tx_zlp
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ues_bank_if bi ();

    ues_state_t  state;
    ues_state_t  next_state;
    logic        tx_complete;
    logic        halt_handshake_sent;
    logic        force_halt_handshake;
    logic        proto_stall;
    logic        setup_seen;
    logic [5:0]  mask;
    logic        commit_req;
    logic        uncommit_req;
    logic        flush_req;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire csr_wr   = reg_wr && reg_addr == ADDR_CSR;
    wire rst_wr   = reg_wr && reg_addr == ADDR_RESET;
    wire fifo_wr  = reg_wr && reg_addr == ADDR_FIFO;
    wire mask_wr  = reg_wr && reg_addr == ADDR_MASK;
    wire rd_csr   = reg_rd && reg_addr == ADDR_CSR;
    wire rd_mask  = reg_rd && reg_addr == ADDR_MASK;
    wire w_pktr   = reg_wdata[CSR_PKTR];

    // status view; packet ready comes from the bank, not from the last write
    wire [5:0] csr_view = {setup_seen, proto_stall, force_halt_handshake,
                           bi.pr_flag, halt_handshake_sent, tx_complete};

    wire [DATA_W-1:0] next_rdata = rd_csr  ? {CSR_PAD, csr_view} :
                                   rd_mask ? {CSR_PAD, mask}     : '0;

    // ----------------------------------------------------------------
    // token decode
    // ----------------------------------------------------------------
    wire idle_tok  = tok_valid && state == ST_IDLE;
    wire halted    = force_halt_handshake || proto_stall;
    wire tok_data  = tok_kind == TOK_IN || tok_kind == TOK_OUT;
    wire stall_evt = idle_tok && tok_data && halted;
    wire in_go     = idle_tok && tok_kind == TOK_IN && !halted && bi.send_ready;
    wire in_nak    = idle_tok && tok_kind == TOK_IN && !halted && !bi.send_ready;
    wire out_ack   = idle_tok && tok_kind == TOK_OUT && !halted;
    wire setup_evt = idle_tok && tok_kind == TOK_SETUP;
    wire ack_evt   = state == ST_WAIT && host_ack;
    wire wait_drop = state == ST_WAIT && !host_ack && tok_valid;
    wire send_done = state == ST_SEND && (bi.rd_last || bi.empty);

    // ----------------------------------------------------------------
    // bank requests
    // ----------------------------------------------------------------
    assign bi.wr_en    = fifo_wr;
    assign bi.wr_data  = reg_wdata[7:0];
    assign bi.commit   = commit_req;
    assign bi.uncommit = uncommit_req;
    assign bi.flush    = flush_req;
    assign bi.start    = in_go;
    assign bi.rd_en    = state == ST_SEND && bi.rd_more;
    assign bi.rel      = ack_evt;
    assign bi.abort    = wait_drop;

    ues_bank #(
        .DEPTH (DEPTH),
        .DUAL  (DUAL_BANK)
    ) u_bank (
        .clk    (clk),
        .arst_n (arst_n),
        .bi     (bi.bank)
    );

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (in_go) next_state = ST_SEND;
            ST_SEND: if (send_done) next_state = ST_WAIT;
            // a fresh token without ACK means the host gave up; keep the bank for retry
            ST_WAIT: if (ack_evt || wait_drop) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // sequencer register; endpoint reset also ends any transfer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= ST_IDLE;
        else if (flush_req)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // sticky flags: set wins over a clearing write in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_complete         <= 1'b0;
            halt_handshake_sent <= 1'b0;
            setup_seen          <= 1'b0;
        end
        else
        begin
            tx_complete         <= ack_evt
                                   || (tx_complete && !(csr_wr && reg_wdata[CSR_TXC]));
            halt_handshake_sent <= stall_evt
                                   || (halt_handshake_sent && !(csr_wr && reg_wdata[CSR_HSENT]));
            setup_seen          <= setup_evt
                                   || (setup_seen && !(csr_wr && reg_wdata[CSR_SETUP]));
        end
    end

    // ----------------------------------------------------------------
    // software controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            force_halt_handshake <= 1'b0;
            proto_stall          <= 1'b0;
            mask                 <= MASK_RST;
        end
        else
        begin
            if (csr_wr)
                force_halt_handshake <= reg_wdata[CSR_FHALT];
            // protocol stall is dropped by the next SETUP; ignored on non-control endpoints
            if (csr_wr && IS_CONTROL && reg_wdata[CSR_PSTALL])
                proto_stall <= 1'b1;
            else if (setup_evt || (csr_wr && !reg_wdata[CSR_PSTALL]))
                proto_stall <= 1'b0;
            if (mask_wr)
                mask <= reg_wdata[5:0];
        end
    end

    // packet ready and endpoint reset are handed to the bank one cycle later
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            commit_req   <= 1'b0;
            uncommit_req <= 1'b0;
            flush_req    <= 1'b0;
        end
        else
        begin
            commit_req   <= csr_wr && w_pktr && !bi.pr_flag;
            uncommit_req <= csr_wr && !w_pktr && bi.pr_flag;
            flush_req    <= rst_wr && reg_wdata[RST_BIT];
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= '0;
            irq       <= 1'b0;
            hs_valid  <= 1'b0;
            hs_pid    <= PID_ACK;
        end
        else
        begin
            reg_rdata <= next_rdata;
            irq       <= |(csr_view & mask & IRQ_BITS);
            hs_valid  <= stall_evt || in_nak || out_ack || setup_evt;
            hs_pid    <= stall_evt ? PID_STALL : (in_nak ? PID_NAK : PID_ACK);
        end
    end

    // data stream copies the bank read port; zero-length packets get a marker
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
            tx_zlp   <= 1'b0;
        end
        else
        begin
            tx_valid <= bi.rd_valid;
            tx_data  <= bi.rd_data;
            tx_last  <= bi.rd_last;
            tx_zlp   <= state == ST_SEND && bi.empty;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_halt_gives_stall: assert property (@(posedge clk) disable iff (!arst_n)
        (state == ST_IDLE && tok_valid && tok_data && force_halt_handshake)
        |=> hs_valid && hs_pid == PID_STALL)
        else $error("halted endpoint did not stall");

    a_stall_holds_halt: assert property (@(posedge clk) disable iff (!arst_n)
        (force_halt_handshake && !csr_wr) ##1 (state == ST_IDLE && tok_valid && tok_kind == TOK_IN)
        |=> hs_pid == PID_STALL && !tx_valid)
        else $error("token passed while halt held");

    a_proto_ctrl_only: assert property (@(posedge clk) disable iff (!arst_n)
        !IS_CONTROL |-> !proto_stall)
        else $error("protocol stall on non-control endpoint");

    a_setup_ends_pstall: assert property (@(posedge clk) disable iff (!arst_n)
        (setup_evt && !csr_wr) |=> !proto_stall && hs_pid == PID_ACK)
        else $error("setup did not end protocol stall");

    a_stall_sets_sent: assert property (@(posedge clk) disable iff (!arst_n)
        (hs_valid && hs_pid == PID_STALL) |-> halt_handshake_sent)
        else $error("stall sent without status");

    a_sent_keeps_irq: assert property (@(posedge clk) disable iff (!arst_n)
        (halt_handshake_sent && mask[CSR_HSENT]) [*2] |-> irq)
        else $error("stall status not interrupting");

    a_ack_sets_txc: assert property (@(posedge clk) disable iff (!arst_n)
        ack_evt |=> tx_complete && state == ST_IDLE)
        else $error("host ack did not set tx_complete");

    a_pr_set_lags: assert property (@(posedge clk) disable iff (!arst_n)
        (csr_wr && w_pktr && !bi.pr_flag && state == ST_IDLE && !flush_req && !fifo_wr && !rst_wr)
        |=> !bi.pr_flag)
        else $error("packet ready changed before bank took it");

    a_pr_clear_done: assert property (@(posedge clk) disable iff (!arst_n)
        (csr_wr && !w_pktr && bi.pr_flag && state == ST_IDLE) ##1 (state == ST_IDLE)
        |=> !bi.pr_flag)
        else $error("idle bank not withdrawn");

    a_reset_flushes: assert property (@(posedge clk) disable iff (!arst_n)
        (rst_wr && reg_wdata[RST_BIT]) |-> ##2 (state == ST_IDLE && !bi.pr_flag))
        else $error("endpoint reset kept data");

    c_stall_sent: cover property (@(posedge clk) disable iff (!arst_n)
        hs_valid && hs_pid == PID_STALL);
    c_in_acked: cover property (@(posedge clk) disable iff (!arst_n)
        tx_last ##[1:20] ack_evt);
    c_cancel: cover property (@(posedge clk) disable iff (!arst_n)
        uncommit_req && bi.pr_flag ##[1:20] flush_req);

endmodule

/* File: dv/ues_host_model.sv */
`timescale 1ns/1ns
// usb host stand-in: sends tokens on command, acks IN data after a chosen delay
module ues_host_model
    import ues_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // bench commands
    input  wire logic       go,
    input  wire ues_tok_t   kind,
    input  wire logic [2:0] ack_dly,
    // device side
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    input  wire logic       tx_zlp,
    output logic            tok_valid,
    output ues_tok_t        tok_kind,
    output logic            host_ack
);
    logic [3:0] cnt;

    // ------------------------------------------------------------
    // token pulse and delayed ack
    // ------------------------------------------------------------
    // kind scrambles between tokens so nothing leans on a stale value
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tok_valid <= 1'b0;
            tok_kind  <= TOK_OUT;
            host_ack  <= 1'b0;
            cnt       <= 4'h0;
        end
        else
        begin
            tok_valid <= go;
            tok_kind  <= go ? kind : ues_tok_t'(~tok_kind);
            host_ack  <= (cnt == 4'h1);
            if ((tx_valid && tx_last) || tx_zlp)
                cnt <= {1'b0, ack_dly} + 4'h2;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

/* File: dv/ues_endpoint_test.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module ues_endpoint_test
    import ues_pkg::*;
;
    logic              clk, arst_n, reg_wr, reg_rd, irq, pend;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, ex;
    logic              tok_valid, host_ack, hs_valid, tx_valid, tx_last, tx_zlp, go;
    logic [7:0]        tx_data;
    logic [2:0]        ack_dly;
    ues_tok_t          tok_kind, kind;
    ues_pid_t          hs_pid;
    int                n_errors, comparisons, seed;
    logic [31:0]       rq[$];
    logic [31:0]       hq[$];
    logic [31:0]       tq[$];

    ues_endpoint u_ues_endpoint (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tok_valid(tok_valid),
        .tok_kind(tok_kind), .host_ack(host_ack), .hs_valid(hs_valid), .hs_pid(hs_pid),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_zlp(tx_zlp));
    ues_host_model u_ues_host_model (.clk(clk), .arst_n(arst_n), .go(go), .kind(kind), .ack_dly(ack_dly),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_zlp(tx_zlp), .tok_valid(tok_valid),
        .tok_kind(tok_kind), .host_ack(host_ack));

    // ------------------------------------------------------------
    // clock, watchdog and closing
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // the whole run needs a few hundred cycles; far beyond that means a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    task automatic stop_test();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: oldest note per result; an unexpected result meets x
    // ------------------------------------------------------------
    always @(negedge clk)
    begin
        if (pend)
        begin
            ex = (rq.size() != 0) ? rq.pop_front() : 'x;
            `CHK(reg_rdata, ex)
        end
        if (hs_valid)
        begin
            ex = (hq.size() != 0) ? hq.pop_front() : 'x;
            `CHK(hs_pid, ues_pid_t'(ex[1:0]))
        end
        if (tx_valid || tx_zlp)
        begin
            ex = (tq.size() != 0) ? tq.pop_front() : 'x;
            // tx_data is only meaningful beside tx_valid; a zero-length marker carries no byte
            `CHK({tx_zlp, tx_last, tx_valid ? tx_data : 8'h00}, ex[9:0])
        end
        pend = reg_rd;
    end

    // ------------------------------------------------------------
    // register bus, token and wait tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // queue idle waits are bounded so a missing result shows as a mismatch
    task automatic settle();
        for (int i = 0; i < 60 && (rq.size() + hq.size() + tq.size()) != 0; i++)
            @(posedge clk);
        `CHK(rq.size() + hq.size() + tq.size(), 0)
    endtask

    task automatic tok(input ues_tok_t k, input logic hs, input ues_pid_t p);
        if (hs)
            hq.push_back({30'h0, p});
        @(posedge clk);
        go      <= 1'b1;
        kind    <= k;
        ack_dly <= 3'($random(seed));
        @(posedge clk);
        go <= 1'b0;
        settle();
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 60 && irq !== 1'b1; i++)
            @(posedge clk);
        `CHK(irq, 1'b1)
    endtask

    task automatic fill(input int n, input logic keep);
        logic [7:0] b;
        for (int i = 0; i < n; i++)
        begin
            b = 8'($random(seed));
            wr(ADDR_FIFO, {24'h0, b});
            if (keep)
                tq.push_back({22'h0, 1'b0, i == n - 1, b});
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h4473e833;
        {arst_n, reg_wr, reg_rd, go, ack_dly} = '0;
        {reg_addr, reg_wdata, n_errors, comparisons} = '0;
        kind = TOK_OUT;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_CSR, 32'h0);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        wr(ADDR_MASK, 32'h23);
        rd(ADDR_MASK, 32'h23);
        $display("test reset done");
        // IN packets of random length, host acks after a random delay
        // the next packet is queued before tx_complete is cleared, so the host never meets an empty bank
        for (int p = 0; p < 3; p++)
        begin
            fill(1 + ($random(seed) & 3), 1'b1);
            wr(ADDR_CSR, 32'h4);
            rd(ADDR_CSR, (p == 0) ? 32'h4 : 32'h5);
            wr(ADDR_CSR, 32'h5);
            rd(ADDR_CSR, 32'h4);
            `CHK(irq, 1'b0)
            tok(TOK_IN, 1'b0, PID_ACK);
            wait_irq();
            rd(ADDR_CSR, 32'h1);
        end
        wr(ADDR_CSR, 32'h1);
        rd(ADDR_CSR, 32'h0);
        `CHK(irq, 1'b0)
        tok(TOK_IN, 1'b1, PID_NAK);
        $display("test in_data done");
        // forced halt stalls IN and OUT, never SETUP
        wr(ADDR_CSR, 32'h8);
        tok(TOK_IN, 1'b1, PID_STALL);
        wait_irq();
        tok(TOK_OUT, 1'b1, PID_STALL);
        tok(TOK_SETUP, 1'b1, PID_ACK);
        rd(ADDR_CSR, 32'h2A);
        wr(ADDR_CSR, 32'h22);
        rd(ADDR_CSR, 32'h0);
        `CHK(irq, 1'b0)
        tok(TOK_OUT, 1'b1, PID_ACK);
        // protocol stall ends at SETUP
        wr(ADDR_CSR, 32'h10);
        tok(TOK_OUT, 1'b1, PID_STALL);
        tok(TOK_SETUP, 1'b1, PID_ACK);
        rd(ADDR_CSR, 32'h22);
        wr(ADDR_CSR, 32'h22);
        tok(TOK_OUT, 1'b1, PID_ACK);
        $display("test stall done");
        // cancel: withdraw, reset, then an empty commit must send a zlp
        fill(3, 1'b0);
        wr(ADDR_CSR, 32'h4);
        rd(ADDR_CSR, 32'h4);
        wr(ADDR_CSR, 32'h0);
        rd(ADDR_CSR, 32'h0);
        wr(ADDR_RESET, 32'h1);
        wr(ADDR_CSR, 32'h4);
        tq.push_back(32'h200);
        tok(TOK_IN, 1'b0, PID_ACK);
        wait_irq();
        wr(ADDR_CSR, 32'h1);
        rd(ADDR_CSR, 32'h0);
        settle();
        $display("test cancel done");
        stop_test();
    end
endmodule
